// ### cog_pkg.sv
`default_nettype none
package cog_pkg;

	// Default sizes
	localparam int COG_NSRC = 4;
	localparam int COG_NSD = 2;
	localparam int COG_NTCLK = 3;
	localparam int COG_NPIN = 4;
	localparam int COG_CNT_W = 6;
	localparam int COG_NOUT = 4;

	// Output index in the drive vector
	localparam int COG_OUT_A = 0;
	localparam int COG_OUT_B = 1;
	localparam int COG_OUT_C = 2;
	localparam int COG_OUT_D = 3;

	// Values after reset
	localparam logic [3:0] COG_RST_DRIVE = 4'h0;
	localparam logic [3:0] COG_RST_OE = 4'h0;
	localparam logic [3:0] COG_RST_STEER = 4'h0;

	// Timing clock select code that means the module clock itself
	localparam logic [1:0] COG_TCLK_SYS = 2'h0;

	typedef enum logic [2:0] {
		COG_MD_STEER = 3'b000,
		COG_MD_SYNC_STEER = 3'b001,
		COG_MD_FWD_FULL = 3'b010,
		COG_MD_REV_FULL = 3'b011,
		COG_MD_HALF = 3'b100,
		COG_MD_PUSH_PULL = 3'b101
	} cog_mode_t;

	typedef enum logic [1:0] {
		COG_OVR_INACTIVE = 2'b00,
		COG_OVR_HIZ = 2'b01,
		COG_OVR_LOW = 2'b10,
		COG_OVR_HIGH = 2'b11
	} cog_ovr_t;

endpackage
`default_nettype wire

// ### cog_timer.sv
`default_nettype none
module cog_timer #(
	parameter int CNT_W = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [CNT_W-1:0] load_i,
	input wire logic tick_i,
	output logic busy_o,
	output logic done_o
);
	logic [CNT_W-1:0] cnt;
	wire load_zero = (load_i == '0);
	wire last_tick = tick_i && (cnt == CNT_W'(1));

	// A zero load finishes in the start cycle so no delay is added
	assign done_o = start_i ? load_zero : last_tick;
	assign busy_o = (cnt != '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
		end else if (start_i) begin
			cnt <= load_i;
		end else if (tick_i && busy_o) begin
			cnt <= cnt - CNT_W'(1);
		end
	end
endmodule
`default_nettype wire

// ### cog_generator.sv
// Summary of operation
// - One PWM input yields a complementary pair of drive signals.
// - Separate rising and falling events can build single or complementary PWM.
// - Each rising event starts a new output period.
// - Active drive lasts from rising event to following falling event.
// - Event sources may be synchronous or asynchronous; all are synchronised.
// - Phase, blanking and clocked dead band count a selectable timing clock.
// - Dead band may instead use a delay chain independent of the timing clock.
// - A 3-bit mode field selects one of six operating modes.
// - Four drive outputs; each pin selects which output it carries.
// - Rise and fall sources selected independently, each edge or level sensitive.
// - Each drive output has its own active polarity.
// - Separate rising and falling phase delays postpone drive changes.
// - Separate rising and falling dead band, clocked or chained.
// - Falls blanked after a rising drive edge, rises after a falling one.
// - Any enabled shutdown source ends active drive at once.
// - Shutdown overrides each output high, low, inactive or high-Z; optional auto-restart.
`default_nettype none
module cog_generator import cog_pkg::*; #(
	parameter int NSRC = COG_NSRC,
	parameter int NSD = COG_NSD,
	parameter int NTCLK = COG_NTCLK,
	parameter int NPIN = COG_NPIN,
	parameter int CNT_W = COG_CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [2:0] operating_mode_field_i,
	input wire logic [1:0] timing_clock_select_i,
	input wire logic [NTCLK-1:0] timing_clock_src_i,
	input wire logic [NSRC-1:0] rise_src_i,
	input wire logic [NSRC-1:0] rise_src_en_i,
	input wire logic [NSRC-1:0] rise_level_i,
	input wire logic [NSRC-1:0] fall_src_i,
	input wire logic [NSRC-1:0] fall_src_en_i,
	input wire logic [NSRC-1:0] fall_level_i,
	input wire logic [CNT_W-1:0] rise_phase_i,
	input wire logic [CNT_W-1:0] fall_phase_i,
	input wire logic [CNT_W-1:0] rise_blank_i,
	input wire logic [CNT_W-1:0] fall_blank_i,
	input wire logic [CNT_W-1:0] rise_dead_i,
	input wire logic [CNT_W-1:0] fall_dead_i,
	input wire logic dead_chain_i,
	input wire logic [3:0] polarity_i,
	input wire logic [3:0] steer_en_i,
	input wire logic [3:0] steer_data_i,
	input wire logic [NSD-1:0] shutdown_src_i,
	input wire logic [NSD-1:0] shutdown_en_i,
	input wire logic shutdown_sw_i,
	input wire logic auto_restart_i,
	input wire logic shutdown_clear_i,
	input wire logic [7:0] shutdown_override_i,
	input wire logic shutdown_irq_en_i,
	input wire logic shutdown_flag_clear_i,
	input wire logic [2*NPIN-1:0] pin_output_source_select_i,
	output logic drive_out_a_o,
	output logic drive_out_a_oe_o,
	output logic drive_out_b_o,
	output logic drive_out_b_oe_o,
	output logic drive_out_c_o,
	output logic drive_out_c_oe_o,
	output logic drive_out_d_o,
	output logic drive_out_d_oe_o,
	output logic [NPIN-1:0] pin_o,
	output logic [NPIN-1:0] pin_oe_o,
	output logic shutdown_active_o,
	output logic shutdown_flag_o,
	output logic shutdown_irq_o
);
	// Input synchronisers; stage m feeds only stage s
	logic [NSRC-1:0] rise_m;
	logic [NSRC-1:0] rise_s;
	logic [NSRC-1:0] rise_d;
	logic [NSRC-1:0] fall_m;
	logic [NSRC-1:0] fall_s;
	logic [NSRC-1:0] fall_d;
	logic [NSD-1:0] sd_m;
	logic [NSD-1:0] sd_s;
	logic [NTCLK-1:0] tclk_m;
	logic [NTCLK-1:0] tclk_s;
	logic [NTCLK-1:0] tclk_d;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rise_m <= '0;
			rise_s <= '0;
			rise_d <= '0;
			fall_m <= '0;
			fall_s <= '0;
			fall_d <= '0;
			sd_m <= '0;
			sd_s <= '0;
			tclk_m <= '0;
			tclk_s <= '0;
			tclk_d <= '0;
		end else begin
			rise_m <= rise_src_i;
			rise_s <= rise_m;
			rise_d <= rise_s;
			fall_m <= fall_src_i;
			fall_s <= fall_m;
			fall_d <= fall_s;
			sd_m <= shutdown_src_i;
			sd_s <= sd_m;
			tclk_m <= timing_clock_src_i;
			tclk_s <= tclk_m;
			tclk_d <= tclk_s;
		end
	end

	// Timing clock: the module clock or a rising edge of a synchronised source
	wire [NTCLK:0] tick_vec = {tclk_s & ~tclk_d, 1'b1};
	wire tick = (timing_clock_select_i == COG_TCLK_SYS) ? 1'b1 :
		tick_vec[timing_clock_select_i];
	// The chain runs on every module clock, whatever timing clock is chosen
	wire dead_tick = dead_chain_i ? 1'b1 : tick;

	// Rises detect the active level or its leading edge; falls the inactive level or trailing edge
	wire [NSRC-1:0] rise_hit = rise_s & (rise_level_i | ~rise_d);
	wire [NSRC-1:0] fall_hit = ~fall_s & (fall_level_i | fall_d);
	// A shared source on both sides gives the PWM input its own duty cycle
	wire rise_any = |(rise_hit & rise_src_en_i);
	wire fall_any = |(fall_hit & fall_src_en_i);

	logic pwm_raw;
	logic pwm_prev;
	logic pp_phase;
	logic [3:0] steer_q;
	logic sd_active;
	logic shut_flag;
	logic [3:0] drive;
	logic [3:0] drive_oe;

	wire ph_r_busy;
	wire ph_r_done;
	wire ph_f_busy;
	wire ph_f_done;
	wire bl_r_busy;
	wire bl_f_busy;
	wire db_r_busy;
	wire db_f_busy;

	// Level inputs fire every cycle, so a new start is only taken when idle
	wire rise_go = enable_i && rise_any && !bl_r_busy && !pwm_raw && !ph_r_busy;
	wire fall_go = enable_i && fall_any && !bl_f_busy && pwm_raw && !ph_f_busy;
	wire raw_rise = pwm_raw && !pwm_prev;
	wire raw_fall = !pwm_raw && pwm_prev;

	cog_timer #(.CNT_W(CNT_W)) u_phase_rise (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(rise_go),
		.load_i(rise_phase_i),
		.tick_i(tick),
		.busy_o(ph_r_busy),
		.done_o(ph_r_done)
	);

	cog_timer #(.CNT_W(CNT_W)) u_phase_fall (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(fall_go),
		.load_i(fall_phase_i),
		.tick_i(tick),
		.busy_o(ph_f_busy),
		.done_o(ph_f_done)
	);

	cog_timer #(.CNT_W(CNT_W)) u_blank_fall (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(raw_rise),
		.load_i(fall_blank_i),
		.tick_i(tick),
		.busy_o(bl_f_busy),
		.done_o()
	);

	cog_timer #(.CNT_W(CNT_W)) u_blank_rise (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(raw_fall),
		.load_i(rise_blank_i),
		.tick_i(tick),
		.busy_o(bl_r_busy),
		.done_o()
	);

	cog_timer #(.CNT_W(CNT_W)) u_dead_rise (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(raw_rise),
		.load_i(rise_dead_i),
		.tick_i(dead_tick),
		.busy_o(db_r_busy),
		.done_o()
	);

	cog_timer #(.CNT_W(CNT_W)) u_dead_fall (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(raw_fall),
		.load_i(fall_dead_i),
		.tick_i(dead_tick),
		.busy_o(db_f_busy),
		.done_o()
	);

	// Phase-delayed drive state
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			pwm_raw <= 1'b0;
			pwm_prev <= 1'b0;
		end else begin
			pwm_prev <= pwm_raw;
			if (ph_r_done) begin
				pwm_raw <= 1'b1;
			end else if (ph_f_done) begin
				pwm_raw <= 1'b0;
			end
		end
	end

	// Complement stays off until the first cycle has run
	logic pwm_prev_any;

	// Dead band: the turning-on side waits, the turning-off side drops at once
	wire rise_wait = db_r_busy || (raw_rise && (rise_dead_i != '0));
	wire fall_wait = db_f_busy || (raw_fall && (fall_dead_i != '0));
	wire prim = pwm_raw && !rise_wait;
	wire comp = !pwm_raw && pwm_prev_any && !fall_wait;

	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			pwm_prev_any <= 1'b0;
		end else if (raw_rise) begin
			pwm_prev_any <= 1'b1;
		end
	end

	// Push-pull alternation and synchronous steering latch
	wire sync_mode = (operating_mode_field_i == COG_MD_SYNC_STEER);
	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			pp_phase <= 1'b0;
			steer_q <= COG_RST_STEER;
		end else begin
			// Flip at the end of active drive so a whole pulse stays on one pair
			if (raw_fall) begin
				pp_phase <= !pp_phase;
			end
			// Steering changes mid-cycle would truncate a pulse, so wait for a rising event
			if (rise_go) begin
				steer_q <= steer_en_i;
			end
		end
	end
	wire [3:0] steer_use = sync_mode ? steer_q : steer_en_i;

	// Mode decode to active-high waveforms per output
	logic [3:0] act;
	always_comb begin
		act = 4'h0;
		unique case (cog_mode_t'(operating_mode_field_i))
			COG_MD_STEER, COG_MD_SYNC_STEER: begin
				for (int k = 0; k < COG_NOUT; k++) begin
					act[k] = steer_use[k] ? prim : steer_data_i[k];
				end
			end
			COG_MD_FWD_FULL: begin
				act[COG_OUT_A] = 1'b1;
				act[COG_OUT_D] = prim;
			end
			COG_MD_REV_FULL: begin
				act[COG_OUT_B] = prim;
				act[COG_OUT_C] = 1'b1;
			end
			COG_MD_HALF: begin
				act[COG_OUT_A] = prim;
				act[COG_OUT_B] = comp;
				act[COG_OUT_C] = prim;
				act[COG_OUT_D] = comp;
			end
			COG_MD_PUSH_PULL: begin
				act[COG_OUT_A] = prim && pp_phase;
				act[COG_OUT_B] = prim && !pp_phase;
				act[COG_OUT_C] = prim && pp_phase;
				act[COG_OUT_D] = prim && !pp_phase;
			end
			default: begin
				act = 4'h0;
			end
		endcase
	end

	// Shutdown: the fault acts combinationally so drive ends without waiting for the latch
	wire fault = enable_i && ((|(sd_s & shutdown_en_i)) || shutdown_sw_i);
	wire shut = sd_active || fault;
	wire restart_ok = auto_restart_i ? rise_any : shutdown_clear_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || !enable_i) begin
			sd_active <= 1'b0;
		end else if (fault) begin
			sd_active <= 1'b1;
		end else if (restart_ok) begin
			sd_active <= 1'b0;
		end
	end

	// Entry into shutdown sets the flag; the set beats a clear in the same cycle
	wire flag_set = fault && !sd_active;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shut_flag <= 1'b0;
		end else begin
			shut_flag <= flag_set || (shut_flag && !shutdown_flag_clear_i);
		end
	end

	// Per-output polarity, override and disable handling
	logic [3:0] next_drive;
	logic [3:0] next_oe;
	generate
		for (genvar k = 0; k < COG_NOUT; k++) begin : g_out
			wire [1:0] ovr = shutdown_override_i[2*k+:2];
			wire lvl = act[k] ^ polarity_i[k];
			wire ovr_lvl = (ovr == COG_OVR_HIGH) ? 1'b1 :
				(ovr == COG_OVR_LOW) ? 1'b0 : polarity_i[k];
			assign next_drive[k] = !enable_i ? polarity_i[k] :
				shut ? ovr_lvl : lvl;
			assign next_oe[k] = !(enable_i && shut && (ovr == COG_OVR_HIZ));
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive <= COG_RST_DRIVE;
			drive_oe <= COG_RST_OE;
		end else begin
			drive <= next_drive;
			drive_oe <= next_oe;
		end
	end

	// Pin source selection
	generate
		for (genvar p = 0; p < NPIN; p++) begin : g_pin
			wire [1:0] sel = pin_output_source_select_i[2*p+:2];
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_o[p] <= 1'b0;
					pin_oe_o[p] <= 1'b0;
				end else begin
					pin_o[p] <= next_drive[sel];
					pin_oe_o[p] <= next_oe[sel];
				end
			end
		end
	endgenerate

	assign drive_out_a_o = drive[COG_OUT_A];
	assign drive_out_a_oe_o = drive_oe[COG_OUT_A];
	assign drive_out_b_o = drive[COG_OUT_B];
	assign drive_out_b_oe_o = drive_oe[COG_OUT_B];
	assign drive_out_c_o = drive[COG_OUT_C];
	assign drive_out_c_oe_o = drive_oe[COG_OUT_C];
	assign drive_out_d_o = drive[COG_OUT_D];
	assign drive_out_d_oe_o = drive_oe[COG_OUT_D];
	assign shutdown_active_o = sd_active;
	assign shutdown_flag_o = shut_flag;
	assign shutdown_irq_o = shut_flag && shutdown_irq_en_i;
endmodule
`default_nettype wire

// ### cog_checker.sv
`default_nettype none
module cog_checker import cog_pkg::*; #(
	parameter int NSD = COG_NSD,
	parameter int NPIN = COG_NPIN
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [2:0] operating_mode_field_i,
	input wire logic [3:0] polarity_i,
	input wire logic [NSD-1:0] shutdown_src_i,
	input wire logic [NSD-1:0] shutdown_en_i,
	input wire logic auto_restart_i,
	input wire logic shutdown_clear_i,
	input wire logic shutdown_irq_en_i,
	input wire logic shutdown_flag_clear_i,
	input wire logic [2*NPIN-1:0] pin_output_source_select_i,
	input wire logic drive_out_a_o,
	input wire logic drive_out_a_oe_o,
	input wire logic drive_out_b_o,
	input wire logic drive_out_b_oe_o,
	input wire logic drive_out_c_o,
	input wire logic drive_out_c_oe_o,
	input wire logic drive_out_d_o,
	input wire logic drive_out_d_oe_o,
	input wire logic [NPIN-1:0] pin_o,
	input wire logic [NPIN-1:0] pin_oe_o,
	input wire logic shutdown_active_o,
	input wire logic shutdown_flag_o,
	input wire logic shutdown_irq_o
);
	logic [3:0] vec;
	logic [3:0] oev;
	logic [3:0] act;
	assign vec = {drive_out_d_o, drive_out_c_o, drive_out_b_o, drive_out_a_o};
	assign oev = {drive_out_d_oe_o, drive_out_c_oe_o, drive_out_b_oe_o, drive_out_a_oe_o};
	assign act = vec ^ polarity_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Fault held long enough to pass the two-stage synchroniser
	sequence s_fault;
		(enable_i && shutdown_src_i[0] && shutdown_en_i[0]) [*4];
	endsequence
	a_idle_polar: assert property (!enable_i && !$past(rst_i) |=> vec == $past(polarity_i) && oev == 4'hf)
		else $error("drive not inactive while disabled");
	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		a_pin_route: assert property (pin_o[p] == vec[$past(pin_output_source_select_i[2*p+:2])]
			&& pin_oe_o[p] == oev[$past(pin_output_source_select_i[2*p+:2])])
			else $error("pin does not carry its selected output");
	end
	a_fault_stop: assert property (s_fault |=> shutdown_active_o)
		else $error("enabled fault did not shut down");
	a_flag_set: assert property ($rose(shutdown_active_o) |-> ##[0:1] shutdown_flag_o)
		else $error("shutdown flag not set");
	a_flag_hold: assert property (shutdown_flag_o && !shutdown_flag_clear_i && enable_i |=> shutdown_flag_o)
		else $error("shutdown flag lost without clear");
	a_irq_gate: assert property (shutdown_irq_o == (shutdown_flag_o && shutdown_irq_en_i))
		else $error("shutdown irq not flag and enable");
	a_manual_hold: assert property (shutdown_active_o && enable_i && !auto_restart_i && !shutdown_clear_i
		|=> shutdown_active_o)
		else $error("shutdown left without restart or clear");
	a_half_pair: assert property (operating_mode_field_i == COG_MD_HALF && $past(operating_mode_field_i) == COG_MD_HALF
		&& enable_i && $past(enable_i) && $stable(polarity_i) && !shutdown_active_o && !$past(shutdown_active_o)
		|-> act[0] == act[2] && act[1] == act[3] && !(act[0] && act[1]))
		else $error("half bridge pair not complementary");
endmodule
`default_nettype wire

// ### cog_bridge_model.sv
`default_nettype none
module cog_bridge_model (
	input wire logic clk_i,
	input wire logic src_req_i,
	input wire logic fault_req_i,
	output logic src_o,
	output logic fault_o,
	output logic [2:0] tick_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic s = 1'b0;
	logic f = 1'b0;
	logic [1:0] div = 2'h0;
	// Edges land 3 ns after the clock so the block must synchronise them
	always @(posedge clk_i) begin
		s <= #3 src_req_i;
		f <= #3 fault_req_i;
		div <= div + 2'h1;
	end
	assign src_o = s;
	assign fault_o = f;
	assign tick_o = {3{div[1]}};
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb import cog_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0, dead_chain_i = 1'b0, auto_restart_i = 1'b0;
	logic shutdown_clear_i = 1'b0, shutdown_flag_clear_i = 1'b0, shutdown_irq_en_i = 1'b0, shutdown_sw_i = 1'b0;
	logic [2:0] operating_mode_field_i = 3'h4;
	logic [1:0] timing_clock_select_i = 2'h0, shutdown_en_i = 2'h1, shutdown_src_i;
	logic [3:0] rise_src_en_i = 4'h1, fall_src_en_i = 4'h1, rise_level_i = 4'h0, fall_level_i = 4'h0;
	logic [3:0] polarity_i = 4'h0, steer_en_i = 4'h0, steer_data_i = 4'h0, oth = 4'h0;
	logic [5:0] rise_phase_i = 6'h00, fall_phase_i = 6'h00, rise_blank_i = 6'h00, fall_blank_i = 6'h00;
	logic [5:0] rise_dead_i = 6'h00, fall_dead_i = 6'h00;
	logic [7:0] shutdown_override_i = 8'h00, pin_output_source_select_i = 8'he4;
	logic src_req = 1'b0, fault_req = 1'b0, src, fault;
	logic [2:0] timing_clock_src_i;
	logic [3:0] rise_src_i, fall_src_i, pin_o, pin_oe_o;
	logic drive_out_a_o, drive_out_a_oe_o, drive_out_b_o, drive_out_b_oe_o;
	logic drive_out_c_o, drive_out_c_oe_o, drive_out_d_o, drive_out_d_oe_o;
	logic shutdown_active_o, shutdown_flag_o, shutdown_irq_o;
	logic [11:0] obs;
	int cyc = 0, miscompares = 0, compares = 0;
	typedef struct {int due; logic [11:0] e; logic [11:0] m; string n;} cog_note_t;
	cog_note_t q[$];
	logic [2:0] md [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
	logic [3:0] hv [7] = '{4'h0, 4'h0, 4'h9, 4'h6, 4'h5, 4'ha, 4'h5};
	logic [3:0] lv [7] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'ha, 4'h0, 4'h0};
	// One shared source gives both events; spare lines carry noise behind the masks
	assign rise_src_i = {oth[3:1], src};
	assign fall_src_i = rise_src_i;
	assign shutdown_src_i = {oth[0], fault};
	assign obs = {shutdown_active_o, shutdown_flag_o, shutdown_irq_o, 1'b0, drive_out_d_oe_o, drive_out_c_oe_o,
		drive_out_b_oe_o, drive_out_a_oe_o, drive_out_d_o, drive_out_c_o, drive_out_b_o, drive_out_a_o};
	cog_generator dut (.*);
	cog_bridge_model far_side (.clk_i(clk_i), .src_req_i(src_req), .fault_req_i(fault_req), .src_o(src),
		.fault_o(fault), .tick_o(timing_clock_src_i));
	always #5 clk_i = ~clk_i;
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic ck(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic note(int d, logic [11:0] e, logic [11:0] m, string n);
		q.push_back('{cyc + d, e, m, n});
	endtask
	task automatic drv(int d, logic [3:0] x);
		note(d, {8'h00, x ^ polarity_i}, 12'h00f, "drive");
	endtask
	task automatic step(logic v, int d, logic [3:0] x, int w);
		src_req <= v;
		drv(d, x);
		ck(w);
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		while (q.size() > 0 && q[0].due <= cyc) begin
			compares++;
			if ((obs & q[0].m) !== (q[0].e & q[0].m)) begin
				miscompares++;
				$display("mismatch %s expected %h seen %h", q[0].n, q[0].e & q[0].m, obs & q[0].m);
			end
			void'(q.pop_front());
		end
		// Whole run needs about 570 cycles
		if (cyc == 5000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		int seed;
		logic [3:0] hi;
		logic [3:0] lo;
		logic [11:0] e;
		seed = $urandom(32'h0000_02d0);
		ck(5);
		rst_i <= 1'b0;
		polarity_i <= $urandom;
		oth <= $urandom;
		ck(3);
		note(1, {4'h0, 4'hf, polarity_i}, 12'h0ff, "idle");
		ck(2);
		for (int i = 0; i < 7; i++) begin
			// Second push-pull row keeps running to see the alternation
			if (i != 6) enable_i <= 1'b0;
			operating_mode_field_i <= md[i];
			steer_en_i <= $urandom;
			steer_data_i <= $urandom;
			pin_output_source_select_i <= $urandom;
			ck(2);
			enable_i <= 1'b1;
			ck(2);
			hi = (i < 2) ? (steer_en_i | steer_data_i) : hv[i];
			lo = (i < 2) ? (~steer_en_i & steer_data_i) : lv[i];
			step(1'b1, 10, hi, 14);
			step(1'b0, 10, lo, 14);
		end
		enable_i <= 1'b0;
		operating_mode_field_i <= COG_MD_HALF;
		ck(2);
		enable_i <= 1'b1;
		step(1'b1, 10, 4'h5, 14);
		step(1'b0, 10, 4'ha, 14);
		timing_clock_select_i <= 2'h1;
		rise_phase_i <= 6'h03;
		ck(1);
		step(1'b1, 12, 4'ha, 0);
		drv(40, 4'h5);
		ck(44);
		step(1'b0, 10, 4'ha, 14);
		rise_phase_i <= 6'h00;
		rise_dead_i <= 6'h06;
		fall_dead_i <= 6'h06;
		dead_chain_i <= 1'b1;
		ck(1);
		step(1'b1, 9, 4'h0, 0);
		drv(22, 4'h5);
		ck(26);
		step(1'b0, 9, 4'h0, 0);
		drv(22, 4'ha);
		ck(26);
		{rise_dead_i, fall_dead_i, dead_chain_i, timing_clock_select_i} <= '0;
		fall_blank_i <= 6'h0a;
		src_req <= 1'b1;
		ck(3);
		step(1'b0, 20, 4'h5, 24);
		src_req <= 1'b1;
		ck(2);
		step(1'b0, 12, 4'ha, 16);
		fall_blank_i <= 6'h00;
		src_req <= 1'b1;
		ck(12);
		for (int k = 0; k < 4; k++) begin
			shutdown_override_i <= {4{k[1:0]}};
			shutdown_irq_en_i <= $urandom;
			fault_req <= 1'b1;
			ck(1);
			e = {2'b11, shutdown_irq_en_i, 1'b0, (k == 1) ? 4'h0 : 4'hf, (k == 0) ? polarity_i : {4{k[0]}}};
			note(7, e, (k == 1) ? 12'hff0 : 12'hfff, "shutdown");
			ck(10);
			fault_req <= 1'b0;
			ck(6);
			note(1, 12'h800, 12'h800, "held");
			ck(1);
			{shutdown_clear_i, shutdown_flag_clear_i} <= 2'b11;
			ck(1);
			{shutdown_clear_i, shutdown_flag_clear_i} <= 2'b00;
			note(4, 12'h000, 12'hc00, "cleared");
			ck(6);
		end
		auto_restart_i <= 1'b1;
		fault_req <= 1'b1;
		ck(10);
		{fault_req, src_req} <= 2'b00;
		ck(8);
		step(1'b1, 10, 4'h5, 14);
		note(0, 12'h000, 12'h800, "restart");
		ck(4);
		test_done();
	end
endmodule
bind cog_generator cog_checker #(.NSD(NSD), .NPIN(NPIN)) chk (.*);
`default_nettype wire
